// >>> logic/ccmc_pkg.sv
// constants and types shared by the capacitor code mode control block
package ccmc_pkg;
  // capacitor code geometry
  localparam int CODE_W = 9;
  localparam int NIB_W = 4;
  localparam int NIB_AW = 2;
  localparam logic [CODE_W-1:0] CODE_MIN = 9'h000;
  localparam logic [CODE_W-1:0] CODE_MAX = 9'h1FF;
  // non-volatile nibble addresses
  localparam logic [NIB_AW-1:0] NIB_ADDR_HI = 2'h2;
  localparam logic [NIB_AW-1:0] NIB_ADDR_MID = 2'h1;
  localparam logic [NIB_AW-1:0] NIB_ADDR_LO = 2'h0;
  // serial command word layout: {address byte, first config byte, second config byte}
  localparam int CMD_W = 24;
  localparam int ADDR_BYTE_LSB = 16;
  localparam int CFG1_LSB = 8;
  localparam int CFG0_LSB = 0;
  localparam int RW_BIT = 0;
  localparam int CFG1_SEL_BIT = 7;
  localparam int CFG1_NIB_MSB = 6;
  localparam int CFG1_NIB_LSB = 5;
  localparam int CFG1_SETNV_BIT = 4;
  localparam int CFG1_CODE8_BIT = 0;
  localparam logic SEL_PERSISTENT = 1'b1;
  localparam logic SEL_VOLATILE = 1'b0;
  localparam logic RW_WRITE = 1'b0;
  // register byte offsets
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFS_CMD = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_VCODE = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_PCODE = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_DEVADDR = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_REJECT = 8'h14;
  // status field positions
  localparam int ST_CODE_LSB = 0;
  localparam int ST_MODE_BIT = 16;
  // reset values
  localparam logic [CODE_W-1:0] VCODE_RST = 9'h000;
  localparam logic MODE_RST = 1'b1;
  localparam logic [15:0] REJECT_RST = 16'h0000;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_CMD = 4'h7;
  typedef enum logic [2:0] {
    CCMC_CMD_NONE,
    CCMC_CMD_VWRITE,
    CCMC_CMD_PWRITE,
    CCMC_CMD_SETNV,
    CCMC_CMD_BAD
  } ccmc_cmd_e;
  typedef enum logic [2:0] {
    CCMC_REG_CMD,
    CCMC_REG_STATUS,
    CCMC_REG_VCODE,
    CCMC_REG_PCODE,
    CCMC_REG_DEVADDR,
    CCMC_REG_REJECT,
    CCMC_REG_NONE
  } ccmc_reg_e;
endpackage

// >>> logic/ccmc_nv_store.sv
// three-nibble persistent code store with registered read data
`timescale 1ns/100ps
module ccmc_pcode_store
  import ccmc_pkg::*;
#(
  parameter logic [CODE_W-1:0] INIT_CODE = 9'h100
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [NIB_AW-1:0] wr_addr,
  input wire logic [NIB_W-1:0] wr_data,
  output logic [CODE_W-1:0] rd_code
);
  logic [NIB_W-1:0] nib_q [0:2];

  // contents model persistence, so no reset touches them
  initial begin
    nib_q[0] = INIT_CODE[3:0];
    nib_q[1] = INIT_CODE[7:4];
    nib_q[2] = {3'h0, INIT_CODE[8]};
  end

  // each nibble written on its own, others keep their value
  always_ff @(posedge clk) begin
    if (wr_en && wr_addr <= NIB_ADDR_HI) begin
      nib_q[wr_addr] <= wr_data;
    end
  end

  // assembled code, read out of a register
  always_ff @(posedge clk) begin
    rd_code <= {nib_q[NIB_ADDR_HI][0], nib_q[NIB_ADDR_MID], nib_q[NIB_ADDR_LO]};
  end
endmodule // ccmc_pcode_store

// >>> logic/ccmc_cmd_decode.sv
// decodes one serial write command word into its action
`timescale 1ns/100ps
module ccmc_cmd_decode
  import ccmc_pkg::*;
(
  input wire logic [CMD_W-1:0] cmd,
  input wire logic [6:0] dev_addr,
  output ccmc_cmd_e kind,
  output logic [CODE_W-1:0] vcode,
  output logic [NIB_AW-1:0] nib_addr,
  output logic [NIB_W-1:0] nib_data
);
  logic [7:0] addr_byte;
  logic [7:0] cfg1;
  logic [7:0] cfg0;

  assign addr_byte = cmd[ADDR_BYTE_LSB +: 8];
  assign cfg1 = cmd[CFG1_LSB +: 8];
  assign cfg0 = cmd[CFG0_LSB +: 8];
  // code bit 8 rides in the first byte, bits 7..0 in the second
  assign vcode = {cfg1[CFG1_CODE8_BIT], cfg0};
  assign nib_addr = cfg1[CFG1_NIB_MSB:CFG1_NIB_LSB];
  assign nib_data = cfg0[NIB_W-1:0];

  // foreign address or read bit decodes to no action; the command readback still records it
  always_comb begin
    kind = CCMC_CMD_NONE;
    if (addr_byte[7:1] == dev_addr && addr_byte[RW_BIT] == RW_WRITE) begin
      if (cfg1[CFG1_SEL_BIT] == SEL_VOLATILE) begin
        kind = CCMC_CMD_VWRITE;
      end else if (cfg1[CFG1_SETNV_BIT]) begin
        kind = CCMC_CMD_SETNV;
      end else if (nib_addr <= NIB_ADDR_HI) begin
        kind = CCMC_CMD_PWRITE;
      end else begin
        kind = CCMC_CMD_BAD;
      end
    end
  end
endmodule // ccmc_cmd_decode

// >>> logic/ccmc_top.sv
// capacitor code mode control: mode flag, code sources and register slave
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module ccmc_top
  import ccmc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
  parameter logic [CODE_W-1:0] PCODE_INIT = 9'h100
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [CODE_W-1:0] CAPACITOR_CODE,
  output logic PERSISTENT_MODE
);
  // map a byte address onto a register, shared by both directions
  function automatic ccmc_reg_e reg_of(input logic [AXI_AW-1:0] a);
    case (a)
      OFS_CMD: reg_of = CCMC_REG_CMD;
      OFS_STATUS: reg_of = CCMC_REG_STATUS;
      OFS_VCODE: reg_of = CCMC_REG_VCODE;
      OFS_PCODE: reg_of = CCMC_REG_PCODE;
      OFS_DEVADDR: reg_of = CCMC_REG_DEVADDR;
      OFS_REJECT: reg_of = CCMC_REG_REJECT;
      default: reg_of = CCMC_REG_NONE;
    endcase
  endfunction

  // write channel holding state
  logic aw_held_q;
  logic w_held_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic aw_held_d;
  logic w_held_d;
  ccmc_reg_e wr_reg;

  // read channel state
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_fire;
  ccmc_reg_e rd_reg;
  logic [31:0] rd_word;

  // block state
  logic [CODE_W-1:0] vcode_q;
  logic pmode_q;
  logic [CODE_W-1:0] cap_code_q;
  logic [CMD_W-1:0] last_cmd_q;
  logic [15:0] reject_q;
  logic [CODE_W-1:0] pcode;
  logic cmd_go;
  ccmc_cmd_e cmd_kind;
  logic [CODE_W-1:0] cmd_vcode;
  logic [NIB_AW-1:0] cmd_nib_addr;
  logic [NIB_W-1:0] cmd_nib_data;
  logic pstore_wr;
  logic do_vwrite;
  logic do_setnv;
  logic do_reject;

  // handshake terms
  assign aw_fire = S_AXI_AWVALID && awready_q;
  assign w_fire = S_AXI_WVALID && wready_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wr_reg = reg_of(awaddr_q);
  assign ar_fire = S_AXI_ARVALID && arready_q;
  assign rd_reg = reg_of(S_AXI_ARADDR);

  // next holding flags; a channel reopens once its item is consumed
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    if (wr_go) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
    end
    if (aw_fire) begin
      aw_held_d = 1'b1;
    end
    if (w_fire) begin
      w_held_d = 1'b1;
    end
  end

  // address parked until the write executes; either order is fine
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_held_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
    end
  end

  // data parked until the write executes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      w_held_q <= 1'b0;
    end else begin
      w_held_q <= w_held_d;
    end
  end

  // address channel open only while no address is parked
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      awready_q <= 1'b0;
    end else begin
      awready_q <= !aw_held_d;
    end
  end

  // data channel open only while no data is parked
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wready_q <= 1'b0;
    end else begin
      wready_q <= !w_held_d;
    end
  end

  // address payload, no reset needed since flags guard its use
  always_ff @(posedge CLK) begin
    if (aw_fire) begin
      awaddr_q <= S_AXI_AWADDR;
    end
  end

  // data payload and strobes, guarded the same way
  always_ff @(posedge CLK) begin
    if (w_fire) begin
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end
  end

  // write answer stands until the master takes it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bvalid_q <= 1'b0;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
    end else if (bvalid_q && S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // unmapped or read-only targets answer with an error
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bresp_q <= (wr_reg == CCMC_REG_CMD) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // a command runs only when all three bytes arrive in one write
  assign cmd_go = wr_go && wr_reg == CCMC_REG_CMD && (wstrb_q & STRB_CMD) == STRB_CMD;

  // one strobe per executed command kind, so no two kinds can overlap
  assign do_vwrite = cmd_go && cmd_kind == CCMC_CMD_VWRITE;
  assign do_setnv = cmd_go && cmd_kind == CCMC_CMD_SETNV;
  assign do_reject = cmd_go && cmd_kind == CCMC_CMD_BAD;

  ccmc_cmd_decode u_decode (
    .cmd(wdata_q[CMD_W-1:0]),
    .dev_addr(DEV_ADDR),
    .kind(cmd_kind),
    .vcode(cmd_vcode),
    .nib_addr(cmd_nib_addr),
    .nib_data(cmd_nib_data)
  );

  assign pstore_wr = cmd_go && cmd_kind == CCMC_CMD_PWRITE;

  // erase is simply a zero nibble; programming time is the master's to respect
  ccmc_pcode_store #(
    .INIT_CODE(PCODE_INIT)
  ) u_store (
    .clk(CLK),
    .wr_en(pstore_wr),
    .wr_addr(cmd_nib_addr),
    .wr_data(cmd_nib_data),
    .rd_code(pcode)
  );

  // volatile code register, cleared like a power cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      vcode_q <= VCODE_RST;
    end else if (do_vwrite) begin
      vcode_q <= cmd_vcode;
    end
  end

  // mode flag: set means persistent source; a write and set-mode never coincide
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pmode_q <= MODE_RST;
    end else if (do_vwrite) begin
      pmode_q <= 1'b0;
    end else if (do_setnv) begin
      pmode_q <= 1'b1;
    end
  end

  // source multiplexer; one register stage keeps the output glitch free
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cap_code_q <= CODE_MIN;
    end else begin
      cap_code_q <= pmode_q ? pcode : vcode_q;
    end
  end

  // last accepted command word, for software readback
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      last_cmd_q <= '0;
    end else if (cmd_go) begin
      last_cmd_q <= wdata_q[CMD_W-1:0];
    end
  end

  // counts commands for this device that name a nibble beyond the top one
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reject_q <= REJECT_RST;
    end else if (do_reject && reject_q != 16'hFFFF) begin
      reject_q <= reject_q + 16'h0001;
    end
  end

  // read multiplexer, unused bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_reg)
      CCMC_REG_CMD: rd_word[CMD_W-1:0] = last_cmd_q;
      CCMC_REG_STATUS: begin
        rd_word[ST_CODE_LSB +: CODE_W] = cap_code_q;
        rd_word[ST_MODE_BIT] = pmode_q;
      end
      CCMC_REG_VCODE: rd_word[CODE_W-1:0] = vcode_q;
      CCMC_REG_PCODE: rd_word[CODE_W-1:0] = pcode;
      CCMC_REG_DEVADDR: rd_word[6:0] = DEV_ADDR;
      CCMC_REG_REJECT: rd_word[15:0] = reject_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // one read in flight; address channel closes until data is taken
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      arready_q <= 1'b0;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q || S_AXI_RREADY) begin
      arready_q <= 1'b1;
    end
  end

  // read answer stands until the master takes it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // read word frozen when the address is taken, so later writes cannot tear it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (ar_fire) begin
      rdata_q <= rd_word;
    end
  end

  // unmapped offsets answer with an error and zero data
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rresp_q <= (rd_reg == CCMC_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // every output straight from a flip-flop
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign CAPACITOR_CODE = cap_code_q;
  assign PERSISTENT_MODE = pmode_q;
endmodule // ccmc_top

// >>> bench/ccmc_properties.sv
// port assertions for the capacitor code mode control block
`timescale 1ns/100ps
module ccmc_properties
  import ccmc_pkg::*;
(
  input logic CLK,
  input logic RST_N,
  input logic S_AXI_AWVALID,
  input logic S_AXI_AWREADY,
  input logic S_AXI_WVALID,
  input logic S_AXI_WREADY,
  input logic [1:0] S_AXI_BRESP,
  input logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic S_AXI_RVALID,
  input logic [CODE_W-1:0] CAPACITOR_CODE,
  input logic PERSISTENT_MODE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // mode moves only with a write answer; code settles one or two cycles later
  property p_rst; $rose(RST_N) |-> PERSISTENT_MODE; endproperty
  a_rst: assert property (p_rst) else $error("mode after reset");
  property p_vol; $fell(PERSISTENT_MODE) |-> $rose(S_AXI_BVALID); endproperty
  a_vol: assert property (p_vol) else $error("volatile without write");
  property p_pers; $rose(PERSISTENT_MODE) |-> $rose(S_AXI_BVALID); endproperty
  a_pers: assert property (p_pers) else $error("persistent without write");
  property p_hold; !$rose(S_AXI_BVALID) |-> $stable(PERSISTENT_MODE); endproperty
  a_hold: assert property (p_hold) else $error("mode drifted");
  property p_code;
    $changed(CAPACITOR_CODE) |-> !$past(RST_N, 2) || $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2);
  endproperty
  a_code: assert property (p_code) else $error("code moved alone");
  property p_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:8] S_AXI_BVALID;
  endproperty
  a_wr: assert property (p_wr) else $error("no write answer");
  property p_rd; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rd: assert property (p_rd) else $error("late read answer");
  property p_bst; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bst: assert property (p_bst) else $error("write answer dropped");
  c_vol: cover property ($fell(PERSISTENT_MODE));
  c_pers: cover property ($rose(PERSISTENT_MODE));
  c_err: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule // ccmc_properties
bind ccmc_top ccmc_properties u_chk (.CLK(CLK), .RST_N(RST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .CAPACITOR_CODE(CAPACITOR_CODE),
  .PERSISTENT_MODE(PERSISTENT_MODE));

// >>> bench/ccmc_host.sv
// bus master standing in for the host that sends serial commands
`timescale 1ns/100ps
module ccmc_host
  import ccmc_pkg::*;
(
  input logic CLK,
  input logic slow,
  output logic [AXI_AW-1:0] awaddr,
  output logic awvalid,
  input logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  output logic bready,
  output logic [AXI_AW-1:0] araddr,
  output logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  output logic rready
);
  // idle at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    int n;
    @(posedge CLK);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 2'b11, !slow};
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wready) {wvalid, wdata} <= {1'b0, ~d};
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1; // slow host only answers after seeing it
    end
    if (n == 50) tb_top.hang();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    {araddr, arvalid, rready} <= {a, 1'b1, !slow};
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (arready) {arvalid, araddr} <= {1'b0, ~a};
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (n == 50) tb_top.hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // ccmc_host

// >>> bench/tb_top.sv
// self-checking bench for the capacitor code mode control block
`timescale 1ns/100ps
module tb_top
  import ccmc_pkg::*;
;
  localparam logic [6:0] DA = 7'h35; // arbitrary bus address
  localparam logic [8:0] PC = 9'h0A5;
  logic CLK, RST_N, slow, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [8:0] code;
  logic [8:0] vc[5] = '{9'h000, 9'h001, 9'h0FF, 9'h100, 9'h1FF};
  logic [8:0] nib_d[3] = '{9'h003, 9'h00C, 9'h001};
  int fail_count = 0;
  int n_compared = 0;
  ccmc_top #(.DEV_ADDR(DA), .PCODE_INIT(PC)) dut (.CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CAPACITOR_CODE(code), .PERSISTENT_MODE(mode));
  ccmc_host m (.*);
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic chk(input string s, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // a bus wait that ran out ends the run
  task automatic hang();
    fail_count++;
    summarize();
  endtask
  // command word: bus address, select, nibble, set-persistent, code
  function automatic logic [31:0] cw(logic [6:0] a, logic s, logic [1:0] nb, logic sn,
    logic [8:0] c);
    return {8'h00, a, RW_WRITE, s, nb, sn, 3'h0, c};
  endfunction
  // settle covers the store path, which lags one more cycle
  task automatic wcmd(input logic [31:0] w, input logic [3:0] s);
    m.wr(OFS_CMD, w, s, r);
    chk("bresp", r, RESP_OKAY);
    repeat (3) @(posedge CLK);
    #1;
  endtask
  task automatic look(input logic em, input logic [8:0] ec);
    chk("mode", mode, em);
    chk("code", code, ec);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    m.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", r, er);
  endtask
  task automatic pwr_cycle();
    RST_N <= 1'b0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  initial begin
    RST_N = 1'b0;
    slow = 1'b0;
    pwr_cycle();
    look(1'b1, PC);
    rchk(OFS_STATUS, {15'h0, 1'b1, 7'h0, PC}, RESP_OKAY);
    rchk(OFS_DEVADDR, {25'h0, DA}, RESP_OKAY);
    m.wr(OFS_DEVADDR, 32'h0000_007F, 4'hF, r);
    chk("bresp", r, RESP_SLVERR);
    rchk(OFS_DEVADDR, {25'h0, DA}, RESP_OKAY);
    // edge codes and the bit 8 carry, back to back
    foreach (vc[i]) begin
      wcmd(cw(DA, SEL_VOLATILE, 2'h0, 1'b0, vc[i]), 4'hF);
      look(1'b0, vc[i]);
    end
    // foreign address and partial strobes leave mode and code unchanged
    wcmd(cw(DA ^ 7'h01, SEL_VOLATILE, 2'h0, 1'b0, 9'h055), 4'hF);
    wcmd(cw(DA, SEL_VOLATILE, 2'h0, 1'b0, 9'h055), 4'h3);
    look(1'b0, 9'h1FF);
    slow = 1'b1;
    foreach (nib_d[i]) wcmd(cw(DA, SEL_PERSISTENT, 2'(i), 1'b0, nib_d[i]), 4'hF);
    look(1'b0, 9'h1FF);
    rchk(OFS_PCODE, 32'h0000_01C3, RESP_OKAY);
    wcmd(cw(DA, SEL_PERSISTENT, 2'h0, 1'b1, 9'h000), 4'hF);
    look(1'b1, 9'h1C3);
    wcmd(cw(DA, SEL_PERSISTENT, 2'h1, 1'b0, 9'h000), 4'hF);
    look(1'b1, 9'h103);
    // a nibble address beyond the top is counted and stores nothing
    wcmd(cw(DA, SEL_PERSISTENT, 2'h3, 1'b0, 9'h00F), 4'hF);
    look(1'b1, 9'h103);
    rchk(OFS_REJECT, 32'h0000_0001, RESP_OKAY);
    rchk(OFS_CMD, cw(DA, SEL_PERSISTENT, 2'h3, 1'b0, 9'h00F), RESP_OKAY);
    rchk(8'h18, 32'h0, RESP_SLVERR);
    wcmd(cw(DA, SEL_VOLATILE, 2'h0, 1'b0, 9'h0AA), 4'hF);
    look(1'b0, 9'h0AA);
    rchk(OFS_VCODE, 32'h0000_00AA, RESP_OKAY);
    @(posedge CLK);
    pwr_cycle();
    look(1'b1, 9'h103);
    rchk(OFS_VCODE, 32'h0, RESP_OKAY);
    rchk(OFS_REJECT, 32'h0, RESP_OKAY);
    summarize();
  end
endmodule // tb_top
